/* include/uic_pkg.sv */
// Package: register map, field positions, resets and carrier types for the USB irq/endpoint block
package uic_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_ENABLE   = 8'hbe;
  localparam logic [7:0] IDX_EP_SELECT    = 8'hc7;
  localparam logic [7:0] IDX_EP_CONTROL   = 8'hd4;
  localparam logic [7:0] IDX_IRQ_FLAGS    = 8'hbd;
  // Flag and enable bit positions
  localparam int BIT_WAKE    = 5;
  localparam int BIT_RST_END = 4;
  localparam int BIT_SOF     = 3;
  localparam int BIT_SUSP    = 0;
  localparam logic [7:0] IRQ_MASK = 8'h39;
  localparam logic [7:0] SEL_MASK = 8'h03;
  // Endpoint control fields
  localparam int BIT_EP_ACTIVE = 7;
  localparam int BIT_NAK_IEN   = 6;
  localparam int BIT_NAK_OUT   = 5;
  localparam int BIT_NAK_IN    = 4;
  localparam int BIT_TOGGLE    = 3;
  localparam int BIT_DIR       = 2;
  localparam logic [7:0] CTL_SW_MASK = 8'hc7;
  // Reset values
  localparam logic [7:0] RST_IRQ_FLAGS  = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] RST_EP_SELECT  = 8'h00;
  localparam logic [7:0] RST_EP_CONTROL = 8'h80;
  // Suspend timing
  localparam int CLK_HZ     = 50_000_000;
  localparam int SUSP_MS    = 3;
  localparam int SUSP_CYC   = CLK_HZ / 1000 * SUSP_MS;
  // Endpoint transfer types
  typedef enum logic [1:0] {EPT_CONTROL = 2'h0, EPT_ISO = 2'h1, EPT_BULK = 2'h2, EPT_INTR = 2'h3} uic_eptype_t;
  // Bus-side events, one-cycle pulses except the bus_j_idle level
  typedef struct packed {
    logic       resume_from_bus;  // Non-idle bus activity during suspend
    logic       resume_upstream;  // Our own remote wake-up signalling
    logic       reset_end;        // End of bus reset
    logic       sof_ok;           // Start of frame received intact
    logic       bus_j_idle;       // Level: bus idle in J
    logic       nak_out;          // NAK sent to OUT
    logic       nak_in;           // NAK sent to IN
    logic       data_rx;          // Data packet received
    logic       data_pid1;        // 1 = DATA1, 0 = DATA0
    logic [1:0] ep;               // Endpoint of the event
  } uic_evt_t;
  // Endpoint configuration seen by the packet engine
  typedef struct packed {
    logic        active;
    logic        dir_in;
    uic_eptype_t ttype;
  } uic_epcfg_t;
endpackage

/* rtl/uic_ctrl.sv */
// USB interrupt flags, enables, endpoint select and per-endpoint control with APB slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Set wake flag on bus resume while suspended, not on own upstream resume.
// - Set reset-end flag at end of bus reset; interrupts when enabled.
// - Set frame-start flag on each good start-of-frame; interrupts when enabled.
// - Set suspend flag after 3 ms of idle J; interrupts when enabled.
// - Reserved bits read zero; software must not write ones there.
// - Each event flag reaches the interrupt only while its enable bit is set.
// - Enable register resets to only the reset-end enable set.
// - Two-bit endpoint index selects which endpoint's indexed registers are reached.
// - Control bit 7 enables the endpoint; control resets to 0x80.
// - Set NAK-out flag of endpoint when NAK answers a host OUT.
// - Set NAK-in flag of endpoint when NAK answers a host IN.
// - NAK flags interrupt only while that endpoint's NAK enable is set.
// - Read-only toggle bit follows DATA1 set, DATA0 clear.
// - Direction bit selects IN/OUT except on control endpoints.
// - Type field decodes 00 control, 01 iso, 10 bulk, 11 interrupt.
module uic_ctrl
  import uic_pkg::*;
#(
  parameter int SUSP_CYCLES = SUSP_CYC,  // Idle-J cycles before suspend
  parameter int NUM_EP      = 4          // Endpoints behind the index
) (
  input  wire logic        mclk,        // 50 MHz clock
  input  wire logic        srst,        // Synchronous reset, high
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB access phase
  input  wire logic        pwrite,      // APB direction
  input  wire logic [11:0] paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error on unmapped
  input  wire uic_evt_t    evt,         // Bus-side events
  output logic             usb_irq,     // Shared USB interrupt
  output logic             suspended,   // Suspend state
  output uic_epcfg_t [3:0] ep_cfg       // Per-endpoint configuration
);

  localparam int CW = $clog2(SUSP_CYCLES + 1);

  // Register state
  logic [7:0]   flags_q, flags_d;
  logic [7:0]   ien_q, ien_d;
  logic [1:0]   sel_q, sel_d;
  logic [7:0]   ctl_q [NUM_EP];
  logic [7:0]   ctl_d [NUM_EP];
  logic [CW-1:0] idle_q, idle_d;
  logic         susp_q, susp_d;
  logic [31:0]  rdata_d;
  logic [31:0]  prdata_q, prdata_d;
  logic         err_d;

  // Byte address of a printed index
  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // Type decode; direction matters only outside control endpoints
  function automatic logic dir_in_of(input logic [7:0] c);
    uic_eptype_t t;
    t = uic_eptype_t'(c[1:0]);
    return (t == EPT_CONTROL) ? 1'b0 : c[BIT_DIR];
  endfunction

  logic acc, wr, rd;
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign pready = 1'b1;  // Zero wait states: every access ends in its first access cycle

  // Suspend detection and event flags
  always_comb begin
    idle_d  = idle_q;
    susp_d  = susp_q;
    flags_d = flags_q;
    if (wr && paddr == addr_of(IDX_IRQ_FLAGS)) begin
      flags_d = flags_q & pwdata[7:0] & IRQ_MASK;  // Clear by writing zero
    end
    if (!evt.bus_j_idle) begin
      idle_d = '0;
    end else if (idle_q < CW'(SUSP_CYCLES)) begin
      idle_d = idle_q + CW'(1);
    end
    if (evt.bus_j_idle && idle_q == CW'(SUSP_CYCLES - 1)) begin
      flags_d[BIT_SUSP] = 1'b1;
      susp_d            = 1'b1;
    end
    if (evt.reset_end) begin
      flags_d[BIT_RST_END] = 1'b1;
      susp_d               = 1'b0;
    end
    if (evt.sof_ok) begin
      flags_d[BIT_SOF] = 1'b1;
    end
    // Own upstream resume leaves suspend without raising the wake flag
    if (susp_q && evt.resume_from_bus && !evt.resume_upstream) begin
      flags_d[BIT_WAKE] = 1'b1;
    end
    if (susp_q && (evt.resume_from_bus || evt.resume_upstream)) begin
      susp_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      flags_q <= RST_IRQ_FLAGS;
      idle_q  <= '0;
      susp_q  <= 1'b0;
    end else begin
      flags_q <= flags_d;
      idle_q  <= idle_d;
      susp_q  <= susp_d;
    end
  end

  // Enable and endpoint select
  always_comb begin
    ien_d = ien_q;
    sel_d = sel_q;
    if (wr && paddr == addr_of(IDX_IRQ_ENABLE)) begin
      ien_d = pwdata[7:0] & IRQ_MASK;
    end
    if (wr && paddr == addr_of(IDX_EP_SELECT)) begin
      sel_d = pwdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ien_q <= RST_IRQ_ENABLE;
      sel_q <= RST_EP_SELECT[1:0];
    end else begin
      ien_q <= ien_d;
      sel_q <= sel_d;
    end
  end

  // Per-endpoint control; hardware bits set after the software write
  always_comb begin
    for (int i = 0; i < NUM_EP; i++) begin
      ctl_d[i] = ctl_q[i];
      if (wr && paddr == addr_of(IDX_EP_CONTROL) && sel_q == 2'(i)) begin
        ctl_d[i] = (pwdata[7:0] & CTL_SW_MASK)
                 | (ctl_q[i] & pwdata[7:0] & 8'h30)   // NAK flags clear by zero
                 | (ctl_q[i] & 8'h08);                // Toggle is read-only
      end
      if (evt.ep == 2'(i)) begin
        if (evt.nak_out) begin
          ctl_d[i][BIT_NAK_OUT] = 1'b1;
        end
        if (evt.nak_in) begin
          ctl_d[i][BIT_NAK_IN] = 1'b1;
        end
        if (evt.data_rx) begin
          ctl_d[i][BIT_TOGGLE] = evt.data_pid1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_EP; i++) begin
      if (srst) begin
        ctl_q[i] <= RST_EP_CONTROL;
      end else begin
        ctl_q[i] <= ctl_d[i];
      end
    end
  end

  // Interrupt combine and endpoint configuration
  logic nak_any;
  always_comb begin
    nak_any = 1'b0;
    for (int i = 0; i < NUM_EP; i++) begin
      nak_any = nak_any | (ctl_q[i][BIT_NAK_IEN] & (ctl_q[i][BIT_NAK_OUT] | ctl_q[i][BIT_NAK_IN]));
    end
  end
  assign usb_irq   = |(flags_q & ien_q) | nak_any;
  assign suspended = susp_q;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ep_cfg[i].active = ctl_q[i][BIT_EP_ACTIVE];
      ep_cfg[i].dir_in = dir_in_of(ctl_q[i]);
      ep_cfg[i].ttype  = uic_eptype_t'(ctl_q[i][1:0]);
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rdata_d = '0;
    err_d   = 1'b0;
    unique case (paddr)
      addr_of(IDX_IRQ_FLAGS):  rdata_d[7:0] = flags_q & IRQ_MASK;
      addr_of(IDX_IRQ_ENABLE): rdata_d[7:0] = ien_q & IRQ_MASK;
      addr_of(IDX_EP_SELECT):  rdata_d[7:0] = {6'h0, sel_q};
      addr_of(IDX_EP_CONTROL): rdata_d[7:0] = ctl_q[sel_q];
      default:                 err_d = 1'b1;
    endcase
  end
  // Read data caught in the setup cycle, held through the access cycle
  // A hardware event landing in the access cycle shows on the next read
  always_comb begin
    prdata_d = '0;
    if (psel && !pwrite) begin
      prdata_d = rd ? prdata_q : rdata_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = acc && err_d;

  // Checks
  sequence s_idle_run;
    evt.bus_j_idle [*8];
  endsequence

  AST_WAKE_ONLY_FROM_BUS: assert property (@(posedge mclk) disable iff (srst)
    evt.resume_upstream && !flags_q[BIT_WAKE] |=> !flags_q[BIT_WAKE])
    else $error("wake flag set by own resume");
  AST_RST_END_SET: assert property (@(posedge mclk) disable iff (srst)
    evt.reset_end |=> flags_q[BIT_RST_END])
    else $error("reset-end flag not set");
  AST_SOF_SET: assert property (@(posedge mclk) disable iff (srst)
    evt.sof_ok |=> flags_q[BIT_SOF])
    else $error("frame-start flag not set");
  AST_SUSP_COUNT: assert property (@(posedge mclk) disable iff (srst)
    !evt.bus_j_idle ##1 s_idle_run |=> idle_q == CW'(8) || SUSP_CYCLES < 8)
    else $error("idle counter not counting idle cycles");
  AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (srst)
    (flags_q & ~IRQ_MASK) == 8'h0 && (ien_q & ~IRQ_MASK) == 8'h0)
    else $error("reserved bit set");
  AST_IRQ_GATED: assert property (@(posedge mclk) disable iff (srst)
    usb_irq == ((flags_q[BIT_WAKE] && ien_q[BIT_WAKE]) || (flags_q[BIT_RST_END] && ien_q[BIT_RST_END])
                || (flags_q[BIT_SOF] && ien_q[BIT_SOF]) || (flags_q[BIT_SUSP] && ien_q[BIT_SUSP]) || nak_any))
    else $error("ungated interrupt");
  AST_IEN_RESET: assert property (@(posedge mclk)
    $past(srst) |-> ien_q == RST_IRQ_ENABLE)
    else $error("enable reset value wrong");
  AST_NAK_OUT_SET: assert property (@(posedge mclk) disable iff (srst)
    evt.nak_out |=> ctl_q[$past(evt.ep)][BIT_NAK_OUT])
    else $error("nak-out flag not set");
  AST_NAK_IN_SET: assert property (@(posedge mclk) disable iff (srst)
    evt.nak_in |=> ctl_q[$past(evt.ep)][BIT_NAK_IN])
    else $error("nak-in flag not set");
  AST_TOGGLE: assert property (@(posedge mclk) disable iff (srst)
    evt.data_rx |=> ctl_q[$past(evt.ep)][BIT_TOGGLE] == $past(evt.data_pid1))
    else $error("toggle wrong");
  AST_CTL_DIR: assert property (@(posedge mclk) disable iff (srst)
    ctl_q[0][1:0] == 2'h0 |-> !ep_cfg[0].dir_in)
    else $error("control endpoint has direction");

  // Software writes, each in its access cycle
  sequence s_wr_flags;
    wr && paddr == addr_of(IDX_IRQ_FLAGS);
  endsequence

  sequence s_wr_ien;
    wr && paddr == addr_of(IDX_IRQ_ENABLE);
  endsequence

  sequence s_wr_sel;
    wr && paddr == addr_of(IDX_EP_SELECT);
  endsequence

  sequence s_wr_ctl;
    wr && paddr == addr_of(IDX_EP_CONTROL);
  endsequence

  // Suspend entry and exit
  AST_SUSP_SET: assert property (@(posedge mclk) disable iff (srst)
    evt.bus_j_idle && idle_q == CW'(SUSP_CYCLES - 1) |=> flags_q[BIT_SUSP] && susp_q)
    else $error("suspend flag missed");
  AST_SUSP_ON_TIME: assert property (@(posedge mclk) disable iff (srst)
    $rose(flags_q[BIT_SUSP]) |-> $past(idle_q) == CW'(SUSP_CYCLES - 1))
    else $error("suspend flag early");
  AST_UPSTREAM_LEAVES: assert property (@(posedge mclk) disable iff (srst)
    susp_q && evt.resume_upstream |=> !susp_q)
    else $error("own resume kept suspend");

  // Wake flag only from bus activity while suspended
  AST_WAKE_SET: assert property (@(posedge mclk) disable iff (srst)
    susp_q && evt.resume_from_bus && !evt.resume_upstream |=> flags_q[BIT_WAKE])
    else $error("wake flag missed");
  AST_WAKE_NOT_AWAKE: assert property (@(posedge mclk) disable iff (srst)
    !susp_q && !flags_q[BIT_WAKE] |=> !flags_q[BIT_WAKE])
    else $error("wake flag set while awake");

  // Set against clear in one cycle
  AST_SOF_SET_WINS: assert property (@(posedge mclk) disable iff (srst)
    evt.sof_ok ##0 s_wr_flags |=> flags_q[BIT_SOF])
    else $error("clear beat frame-start set");
  AST_NAK_SET_WINS: assert property (@(posedge mclk) disable iff (srst)
    evt.nak_out ##0 s_wr_ctl |=> ctl_q[$past(evt.ep)][BIT_NAK_OUT])
    else $error("clear beat nak set");
  AST_FLAG_CLEAR: assert property (@(posedge mclk) disable iff (srst)
    s_wr_flags ##0 (!pwdata[BIT_SOF] && !evt.sof_ok) |=> !flags_q[BIT_SOF])
    else $error("flag not cleared by zero");

  // Enables and selection
  AST_IEN_WRITE: assert property (@(posedge mclk) disable iff (srst)
    s_wr_ien |=> ien_q == ($past(pwdata[7:0]) & IRQ_MASK))
    else $error("enable write wrong");
  AST_WAKE_IRQ: assert property (@(posedge mclk) disable iff (srst)
    flags_q[BIT_WAKE] && ien_q[BIT_WAKE] |-> usb_irq)
    else $error("enabled wake flag gives no interrupt");
  AST_SEL_WRITE: assert property (@(posedge mclk) disable iff (srst)
    s_wr_sel |=> sel_q == $past(pwdata[1:0]))
    else $error("endpoint select write wrong");
  AST_CTL_SELECTED: assert property (@(posedge mclk) disable iff (srst)
    s_wr_ctl |=> ctl_q[$past(sel_q)][BIT_EP_ACTIVE] == $past(pwdata[BIT_EP_ACTIVE]))
    else $error("control write missed selected endpoint");

  // Endpoint control fields
  AST_CTL_RESET: assert property (@(posedge mclk)
    $past(srst) |-> ctl_q[0] == RST_EP_CONTROL && ctl_q[3] == RST_EP_CONTROL)
    else $error("control reset value wrong");
  AST_TOGGLE_RO: assert property (@(posedge mclk) disable iff (srst)
    s_wr_ctl ##0 !evt.data_rx |=> ctl_q[$past(sel_q)][BIT_TOGGLE] == $past(ctl_q[sel_q][BIT_TOGGLE]))
    else $error("toggle written by software");
  AST_NAK_IRQ: assert property (@(posedge mclk) disable iff (srst)
    ctl_q[2][BIT_NAK_IEN] && ctl_q[2][BIT_NAK_IN] |-> usb_irq)
    else $error("enabled nak gives no interrupt");
  AST_BULK_DECODE: assert property (@(posedge mclk) disable iff (srst)
    ctl_q[2][1:0] == 2'h2 |-> ep_cfg[2].ttype == EPT_BULK && ep_cfg[2].dir_in == ctl_q[2][BIT_DIR])
    else $error("bulk endpoint decode wrong");
endmodule

/* verif/uic_ctrl_bench.sv */
// Self-checking bench for the USB interrupt and endpoint control block
`timescale 1ns/1ps
module uic_ctrl_bench;
  import uic_pkg::*;
  localparam int          SN    = 20;
  localparam logic [11:0] A_FLG = {2'h0, IDX_IRQ_FLAGS, 2'h0};
  localparam logic [11:0] A_IEN = {2'h0, IDX_IRQ_ENABLE, 2'h0};
  localparam logic [11:0] A_SEL = {2'h0, IDX_EP_SELECT, 2'h0};
  localparam logic [11:0] A_CTL = {2'h0, IDX_EP_CONTROL, 2'h0};
  logic             mclk       = 1'b0;
  logic             srst       = 1'b1;
  logic             psel       = 1'b0;
  logic             penable    = 1'b0;
  logic             pwrite     = 1'b0;
  logic [11:0]      paddr      = 12'h000;
  logic [31:0]      pwdata     = 32'h0;
  logic [2:0]       cmd        = 3'h0;
  logic [1:0]       ep         = 2'h0;
  logic             pid1       = 1'b0;
  logic             idle       = 1'b0;
  logic [31:0]      seed       = 32'h49;
  logic [31:0]      prdata, r;
  logic             pready, pslverr, usb_irq, suspended;
  uic_epcfg_t [3:0] ep_cfg;
  uic_evt_t         evt;
  logic [32:0]      exq[$];
  int               fail_count = 0;
  int               n_compared = 0;

  uic_ctrl #(.SUSP_CYCLES(SN)) uut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .usb_irq(usb_irq), .suspended(suspended), .ep_cfg(ep_cfg));
  uic_host_model hostm (.mclk(mclk), .cmd(cmd), .ep(ep), .pid1(pid1), .idle(idle), .evt(evt));

  // 50 MHz clock
  always #10 mclk = ~mclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  // APB master; optional event rides in the access cycle to collide with a write
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [2:0] ev);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    cmd     <= ev;
    @(posedge mclk);
    penable <= 1'b1;
    cmd     <= 3'h0;
    do @(posedge mclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic err = 1'b0);
    exq.push_back({err, 24'h0, e});
    apb(1'b0, a, 8'h00, 3'h0);
  endtask

  task automatic chk(input logic v);
    @(negedge mclk);
    cmp({32'h0, usb_irq}, {32'h0, v});
  endtask

  task automatic pulse(input logic [2:0] c);
    @(posedge mclk);
    cmd <= c;
    @(posedge mclk);
    cmd <= 3'h0;
  endtask

  task automatic sus(input int n);
    idle <= 1'b1;
    repeat (n) @(posedge mclk);
    idle <= 1'b0;
  endtask

  // Flag seen, gated by its own enable, then cleared by writing zero
  task automatic fchk(input int b);
    rd(A_FLG, 8'h01 << b);
    chk(1'b0);
    apb(1'b1, A_IEN, 8'h01 << b, 3'h0);
    chk(1'b1);
    apb(1'b1, A_FLG, 8'h00, 3'h0);
    chk(1'b0);
    apb(1'b1, A_IEN, 8'h00, 3'h0);
  endtask

  // Read results leave the queue in issue order
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) begin
      cmp({pslverr, prdata}, exq.pop_front());
    end
  end

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rd(A_FLG, RST_IRQ_FLAGS);
    rd(A_IEN, RST_IRQ_ENABLE);
    rd(A_SEL, RST_EP_SELECT);
    rd(A_CTL, RST_EP_CONTROL);
    rd(12'hffc, 8'h00, 1'b1);
    r = xs();
    apb(1'b1, A_IEN, r[7:0] & IRQ_MASK, 3'h0);
    rd(A_IEN, r[7:0] & IRQ_MASK);
    apb(1'b1, A_SEL, r[15:8] & SEL_MASK, 3'h0);
    rd(A_SEL, r[15:8] & SEL_MASK);
    apb(1'b1, A_IEN, 8'h00, 3'h0);
    pulse(3'h3);
    fchk(BIT_RST_END);
    pulse(3'h4);
    fchk(BIT_SOF);
    sus(SN - 2);
    rd(A_FLG, 8'h00);
    sus(SN + 3);
    @(negedge mclk);
    cmp({32'h0, suspended}, 33'h1);
    fchk(BIT_SUSP);
    pulse(3'h2);
    rd(A_FLG, 8'h00);
    @(negedge mclk);
    cmp({32'h0, suspended}, 33'h0);
    sus(SN + 3);
    apb(1'b1, A_FLG, 8'h00, 3'h0);
    pulse(3'h1);
    fchk(BIT_WAKE);
    apb(1'b1, A_FLG, 8'h00, 3'h4);
    rd(A_FLG, 8'h08);
    apb(1'b1, A_FLG, 8'h00, 3'h0);
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, A_SEL, t[7:0], 3'h0);
      apb(1'b1, A_CTL, {t != 1, 5'h0f, t[1:0]}, 3'h0);
      rd(A_CTL, {t != 1, 5'h01, t[1:0]});
      @(negedge mclk);
      cmp({29'h0, ep_cfg[t]}, {29'h0, t != 1, t != 0, t[1:0]});
    end
    apb(1'b1, A_SEL, 8'h02, 3'h0);
    ep <= 2'h2;
    pulse(3'h5);
    rd(A_CTL, 8'ha6);
    chk(1'b0);
    apb(1'b1, A_CTL, 8'he6, 3'h0);
    chk(1'b1);
    apb(1'b1, A_CTL, 8'hc6, 3'h0);
    chk(1'b0);
    pulse(3'h6);
    rd(A_CTL, 8'hd6);
    chk(1'b1);
    ep <= 2'h3;
    pulse(3'h5);
    rd(A_CTL, 8'hd6);
    ep   <= 2'h2;
    pid1 <= 1'b1;
    pulse(3'h7);
    rd(A_CTL, 8'hde);
    pid1 <= 1'b0;
    pulse(3'h7);
    rd(A_CTL, 8'hd6);
    conclude();
  end
endmodule

/* verif/uic_host_model.sv */
// Host-side model: turns bench commands into one-cycle bus events
`timescale 1ns/1ps
module uic_host_model
  import uic_pkg::*;
(
  input  wire logic       mclk,  // Bench clock
  input  wire logic [2:0] cmd,   // Event for next cycle, 0 none
  input  wire logic [1:0] ep,    // Endpoint of the event
  input  wire logic       pid1,  // Data packet is DATA1
  input  wire logic       idle,  // Bus held in idle J
  output uic_evt_t        evt    // Events toward the device
);
  // Pulses last one cycle; PID qualifier flips when no data, so stale values never help
  always_ff @(posedge mclk) begin
    evt.bus_j_idle      <= idle;
    evt.ep              <= ep;
    evt.data_pid1       <= (cmd == 3'h7) ? pid1 : ~pid1;
    evt.resume_from_bus <= (cmd == 3'h1);
    evt.resume_upstream <= (cmd == 3'h2);
    evt.reset_end       <= (cmd == 3'h3);
    evt.sof_ok          <= (cmd == 3'h4);
    evt.nak_out         <= (cmd == 3'h5);
    evt.nak_in          <= (cmd == 3'h6);
    evt.data_rx         <= (cmd == 3'h7);
  end
endmodule
